// ---- hdl/jlsp_frame_builder.sv ----
`timescale 1ns/100ps
// Turns one set of lane samples into a left aligned continuous bit stream.
module jlsp_frame_builder (
    // Setup in, frame out.
    jlsp_pack_if.bld pk
);
    import jlsp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Packing.

    // Packed stream, built right aligned and then moved to the top.
    logic [FRAME_W-1:0] acc;
    // One sample after padding, held in its low bits.
    logic [SAMPLE_W-1:0] word;
    // Mask of the valid resolution bits.
    logic [SAMPLE_W-1:0] mask;
    // Stream length in bits.
    logic [7:0] used_bits;

    // Each channel word is appended below the previous one, so channel
    // one ends up first and every word runs MSB first. Words butt against
    // each other with no alignment, so a sample may start mid nibble. The
    // same loop serves whichever channel group the lane carries.
    always_comb begin
        acc = '0;
        word = '0;
        mask = 16'((17'h00001 << pk.sample_resolution) - 17'h00001);
        used_bits = 8'(pk.channels_per_lane * pk.serialized_word_width);
        for (int c = 0; c < CH_MAX; c++) begin
            if (4'(c) < pk.channels_per_lane) begin // RL5
                // Zeros below the LSB fill the word out to its width.
                word = (pk.samples[c] & mask) <<
                       (pk.serialized_word_width - pk.sample_resolution); // RL2 RL6
                acc = (acc << pk.serialized_word_width) |
                      {{(FRAME_W-SAMPLE_W){1'b0}}, word}; // RL1 RL3
            end
        end
        // Left align; bits past the stream stay zero, which also fills
        // a trailing half octet.
        pk.frame = acc << (FRAME_W_BITS - used_bits); // RL4
    end

endmodule : jlsp_frame_builder

// ---- hdl/jlsp_lane_packer.sv ----
`timescale 1ns/100ps
//
// Contract
// (RL1) Channels one to eight, MSB first, nibbles continuous.
// (RL2) Pad wider words with trailing zero bits.
// (RL3) Pad bits stay inside the nibble stream.
// (RL4) 14-in-16, 10-in-12: last nibble ends zeros.
// (RL5) Every lane packs its own channels alike.
// (RL6) Pad count equals width minus resolution.
// (RL7) Channels per lane 8/4/2 sets lanes.
// (RL8) First nibble high; octets in ascending order.
//
module jlsp_lane_packer (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_nrst,
    // Register port.
    input wire logic [3:0] i_reg_addr,
    input wire logic [31:0] i_reg_wdata,
    input wire logic i_reg_write,
    input wire logic i_reg_read,
    output logic [31:0] o_reg_rdata,
    // Sample frame in.
    input wire logic i_frame_valid,
    input wire jlsp_pkg::jlsp_samples_t i_samples,
    output logic o_frame_ready,
    // Octet stream out.
    output logic [7:0] o_octet,
    output logic o_octet_valid,
    output logic o_frame_first,
    output logic o_frame_last,
    // Lanes in use.
    output logic [3:0] o_lane_count
);
    import jlsp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Control register and decoded setup.

    // Software written setup.
    logic [CTRL_USED_W-1:0] ctrl_q;
    // Decoded setup fields.
    logic [4:0] res_bits;
    logic [4:0] ser_raw;
    logic [4:0] ser_bits;
    jlsp_cpl_e cpl;
    logic [3:0] channels;
    logic cfg_err;
    logic enable;

    // Software must set the widths and channel count before enabling.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            ctrl_q <= CTRL_RESET;
        end else if (i_reg_write && i_reg_addr == REG_CTRL) begin
            ctrl_q <= i_reg_wdata[CTRL_USED_W-1:0]; // RL7
        end
    end

    // A word narrower than the sample is illegal; it is widened to the
    // resolution so no sample bit is ever lost, and flagged. The two
    // octet per sample mode is not built here, so asking for it only
    // raises the flag and normal packing continues.
    always_comb begin
        res_bits = width_bits(ctrl_q[CTRL_RES_LSB +: 2]);
        ser_raw = width_bits(ctrl_q[CTRL_SER_LSB +: 2]);
        ser_bits = (ser_raw < res_bits) ? res_bits : ser_raw;
        cpl = jlsp_cpl_e'(ctrl_q[CTRL_CPL_LSB +: 2]);
        channels = cpl_count(cpl); // RL7
        enable = ctrl_q[CTRL_ENABLE_BIT];
        cfg_err = (ser_raw < res_bits) || (cpl == CPL_RSV) ||
                  ctrl_q[CTRL_TWO_OCT_BIT];
    end

    // Lane count follows the channels per lane setting.
    assign o_lane_count = lane_count(cpl); // RL7

    ////////////////////////////////////////////////////////////////////////
    // Frame builder.

    jlsp_pack_if pk ();

    assign pk.sample_resolution = res_bits;
    assign pk.serialized_word_width = ser_bits;
    assign pk.channels_per_lane = channels;
    assign pk.samples = i_samples;

    jlsp_frame_builder u_builder (
        .pk(pk.bld)
    );

    ////////////////////////////////////////////////////////////////////////
    // Octet sequencer.

    // Sequencer state.
    jlsp_state_e state_q;
    // Frame being sent, next octet in the top bits.
    logic [FRAME_W-1:0] frame_q;
    // Octets still to send including the one on the output.
    logic [4:0] rem_q;
    // First octet marker.
    logic first_q;
    // Frames taken, wraps.
    logic [7:0] frames_q;
    // A frame is taken this cycle.
    logic accept;

    // Ready while enabled and idle or on the last octet, so frames run back to back.
    assign o_frame_ready = enable &&
                           (state_q == ST_IDLE || rem_q == 5'h01);
    assign accept = i_frame_valid && o_frame_ready;

    // State and octet count of the frame in flight.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            state_q <= ST_IDLE;
            rem_q <= 5'h00;
        end else if (accept) begin
            state_q <= ST_SEND;
            rem_q <= frame_octets(channels, ser_bits);
        end else if (state_q == ST_SEND) begin
            // The last octet leaves here unless a new frame follows.
            case (rem_q)
                5'h01: state_q <= ST_IDLE;
                default: state_q <= ST_SEND;
            endcase
            rem_q <= rem_q - 5'h01;
        end
    end

    // Frame shifts one octet per cycle, upper nibble first.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            frame_q <= '0;
            first_q <= 1'b0;
        end else if (accept) begin
            frame_q <= pk.frame; // RL8
            first_q <= 1'b1;
        end else begin
            frame_q <= {frame_q[FRAME_W-9:0], 8'h00}; // RL8
            first_q <= 1'b0;
        end
    end

    // Frames counter for status.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            frames_q <= 8'h00;
        end else if (accept) begin
            frames_q <= frames_q + 8'h01;
        end
    end

    assign o_octet = frame_q[FRAME_W-1 -: 8];
    assign o_octet_valid = (state_q == ST_SEND);
    assign o_frame_first = o_octet_valid && first_q;
    assign o_frame_last = o_octet_valid && rem_q == 5'h01;

    ////////////////////////////////////////////////////////////////////////
    // Register read port.

    // Read data stand for one cycle only and are zero otherwise, so a
    // stale value can never be mistaken for an answer.
    always_ff @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            o_reg_rdata <= 32'h0000_0000;
        end else if (i_reg_read && i_reg_addr == REG_CTRL) begin
            o_reg_rdata <= {24'h00_0000, ctrl_q};
        end else if (i_reg_read && i_reg_addr == REG_STATUS) begin
            o_reg_rdata <= 32'h0000_0000;
            o_reg_rdata[STAT_LANES_LSB +: 4] <= o_lane_count;
            o_reg_rdata[STAT_BUSY_BIT] <= o_octet_valid;
            o_reg_rdata[STAT_CFG_ERR_BIT] <= cfg_err;
            o_reg_rdata[STAT_FRAMES_LSB +: 8] <= frames_q;
        end else begin
            // Unmapped reads and idle cycles return zero.
            o_reg_rdata <= 32'h0000_0000;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions.

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_nrst);

    // A frame is taken with a given width pair.
    sequence s_take(logic [4:0] r, logic [4:0] s);
        accept && res_bits == r && ser_bits == s;
    endsequence

    a_first_octet_top: assert property ( // RL8
        accept |=> o_octet == $past(pk.frame[FRAME_W-1 -: 8]) && o_frame_first)
        else $error("first octet is not the top of the packed frame");

    a_msb_first_order: assert property ( // RL1
        s_take(5'h10, 5'h10) |=>
            o_octet == $past(i_samples[0][15:8]) ##1
            o_octet == $past(i_samples[0][7:0], 2) ##1
            o_octet == $past(i_samples[1][15:8], 3))
        else $error("full width samples are not sent in order MSB first");

    a_pad_low_zero: assert property ( // RL4
        s_take(5'h0e, 5'h10) |=> ##1 o_octet[1:0] == 2'b00 &&
            o_octet[3:2] == $past(i_samples[0][1:0], 2))
        else $error("padded sample does not end in two zero bits");

    a_pad_shared_nibble: assert property ( // RL3
        s_take(5'h0c, 5'h0e) |=> ##1 o_octet[3:2] == 2'b00 &&
            o_octet[1:0] == $past(i_samples[1][11:10], 2))
        else $error("pad bits do not share a nibble with the next sample");

    a_split_nibble: assert property ( // RL1
        s_take(5'h0a, 5'h0a) |=> ##1 o_octet[7:6] ==
            $past(i_samples[0][1:0], 2) &&
            o_octet[5:4] == $past(i_samples[1][9:8], 2))
        else $error("sample boundary inside a nibble is wrong");

    a_pad_ten_in_twelve: assert property ( // RL2
        s_take(5'h0a, 5'h0c) |=> ##1 o_octet[5:4] == 2'b00)
        else $error("ten bit sample is not padded with two zeros");

    // Fifteen octets run without the last marker, and the sixteenth
    // carries it; the repetition is split to keep each count small.
    a_frame_length: assert property ( // RL4
        s_take(5'h0e, 5'h10) ##0 channels == 4'h8 |=>
            (o_octet_valid && !o_frame_last)[*8] ##1
            (o_octet_valid && !o_frame_last)[*7] ##1
            (o_octet_valid && o_frame_last))
        else $error("sixteen octet frame is not sixteen octets long");

    a_shift_next: assert property ( // RL8
        o_octet_valid && !o_frame_last && !accept |=>
            o_octet == $past(frame_q[FRAME_W-9 -: 8]))
        else $error("octets are not sent in ascending order");

    a_lane_count: assert property ( // RL7
        (cpl == CPL_8 |-> o_lane_count == 4'h2) and
        (cpl == CPL_4 |-> o_lane_count == 4'h4) and
        (cpl == CPL_2 |-> o_lane_count == 4'h8))
        else $error("lane count does not follow channels per lane");

endmodule : jlsp_lane_packer

// ---- shared/jlsp_pack_if.sv ----
`timescale 1ns/100ps
// Carries the live packing setup to the frame builder and its result back.
interface jlsp_pack_if;
    import jlsp_pkg::*;

    // Sample resolution in bits.
    logic [4:0] sample_resolution;
    // Serialized word width in bits, never below the resolution.
    logic [4:0] serialized_word_width;
    // Channels packed into this lane.
    logic [3:0] channels_per_lane;
    // Samples of the lane's channels in ascending order.
    jlsp_samples_t samples;
    // Packed frame, first bit of the stream in the top bit.
    logic [FRAME_W-1:0] frame;

    // Side that owns the setup and takes the frame.
    modport src (
        output sample_resolution,
        output serialized_word_width,
        output channels_per_lane,
        output samples,
        input frame
    );

    // Side that builds the frame.
    modport bld (
        input sample_resolution,
        input serialized_word_width,
        input channels_per_lane,
        input samples,
        output frame
    );

endinterface : jlsp_pack_if

// ---- shared/jlsp_pkg.sv ----
package jlsp_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register map and field layout.

    // Byte offsets of the two registers on the register port.
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;

    // Control register fields.
    localparam int CTRL_RES_LSB = 0;
    localparam int CTRL_SER_LSB = 2;
    localparam int CTRL_CPL_LSB = 4;
    localparam int CTRL_TWO_OCT_BIT = 6;
    localparam int CTRL_ENABLE_BIT = 7;
    localparam int CTRL_USED_W = 8;

    // Control reset value: 10-bit samples, 10-bit words, eight channels.
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // Status register fields.
    localparam int STAT_LANES_LSB = 0;
    localparam int STAT_BUSY_BIT = 4;
    localparam int STAT_CFG_ERR_BIT = 5;
    localparam int STAT_FRAMES_LSB = 8;

    ////////////////////////////////////////////////////////////////////////
    // Frame geometry.

    // Most channels that share one lane, and the converters in total.
    localparam int CH_MAX = 8;
    localparam logic [4:0] TOTAL_CONVERTERS = 5'h10;
    // Width of one sample slot, right aligned.
    localparam int SAMPLE_W = 16;
    // Widest frame: eight 16-bit words.
    localparam int FRAME_W = CH_MAX * SAMPLE_W;
    localparam logic [7:0] FRAME_W_BITS = 8'h80;
    // Narrowest word; each width setting adds two bits to it.
    localparam logic [4:0] WIDTH_BASE = 5'h0a;

    // One sample per channel of the lane, channel one in index 0.
    typedef logic [CH_MAX-1:0][SAMPLE_W-1:0] jlsp_samples_t;

    // Channels-per-lane setting.
    typedef enum logic [1:0] {
        CPL_8 = 2'b00,
        CPL_4 = 2'b01,
        CPL_2 = 2'b10,
        CPL_RSV = 2'b11
    } jlsp_cpl_e;

    // Packer states.
    typedef enum logic [0:0] {
        ST_IDLE = 1'b0,
        ST_SEND = 1'b1
    } jlsp_state_e;

    // Width in bits for a resolution or serialized width setting.
    function automatic logic [4:0] width_bits(input logic [1:0] sel);
        width_bits = WIDTH_BASE + {2'b00, sel, 1'b0};
    endfunction : width_bits

    // Channels carried by one lane; the reserved code acts as eight.
    function automatic logic [3:0] cpl_count(input jlsp_cpl_e cpl);
        case (cpl)
            CPL_4: cpl_count = 4'h4;
            CPL_2: cpl_count = 4'h2;
            default: cpl_count = 4'h8;
        endcase
    endfunction : cpl_count

    // Lanes in use follow from the channels per lane.
    function automatic logic [3:0] lane_count(input jlsp_cpl_e cpl);
        lane_count = 4'(TOTAL_CONVERTERS / {1'b0, cpl_count(cpl)});
    endfunction : lane_count

    // Octets in one frame, a trailing half octet counting as whole.
    function automatic logic [4:0] frame_octets(input logic [3:0] ch,
                                                input logic [4:0] w);
        logic [8:0] bits;
        bits = 9'(ch * w);
        frame_octets = 5'((bits + 9'h007) >> 3);
    endfunction : frame_octets

endpackage : jlsp_pkg

// ---- tb/jlsp_rx_model.sv ----
`timescale 1ns/100ps
// Receiver at the far end of the lane: takes octets and checks framing.
module jlsp_rx_model (
    // Clock and reset.
    input wire logic i_clock,
    input wire logic i_nrst,
    // Octet stream from the packer.
    input wire logic [7:0] i_octet,
    input wire logic i_octet_valid,
    input wire logic i_frame_first,
    input wire logic i_frame_last
);

    ////////////////////////////////////////////////////////////////////////
    // Octets taken, in arrival order.
    logic [7:0] got[$];
    // Frames begun.
    int frames = 0;
    // Frame marker faults seen.
    int bad = 0;
    // High between the first and the last octet of a frame.
    logic in_frame_q = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // The link has no back-pressure, so every valid cycle is taken.
    // A first marker is legal only outside a frame, and any other octet
    // only inside one; anything else is counted as a framing fault.
    always @(posedge i_clock or negedge i_nrst) begin
        if (!i_nrst) begin
            in_frame_q <= 1'b0;
        end else if (i_octet_valid === 1'b1) begin
            got.push_back(i_octet);
            if (i_frame_first === 1'b1) frames++;
            if (i_frame_first !== !in_frame_q) bad++;
            in_frame_q <= !i_frame_last;
        end
    end

endmodule : jlsp_rx_model

// ---- tb/tb.sv ----
`timescale 1ns/100ps
// Bench: drives registers and sample sets, compares every octet.
module tb;
    import jlsp_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Design inputs, all given a value at time zero.
    logic i_clock = 1'b0;
    logic i_nrst = 1'b0;
    logic [3:0] i_reg_addr = 4'h0;
    logic [31:0] i_reg_wdata = 32'h0;
    logic i_reg_write = 1'b0;
    logic i_reg_read = 1'b0;
    logic i_frame_valid = 1'b0;
    jlsp_samples_t i_samples = '0;
    // Design outputs.
    logic [31:0] o_reg_rdata;
    logic o_frame_ready;
    logic [7:0] o_octet;
    logic o_octet_valid;
    logic o_frame_first;
    logic o_frame_last;
    logic [3:0] o_lane_count;
    // Counters of the run.
    int failures = 0;
    int num_checks = 0;
    // Frames handed over, and the octets the bench model expects.
    int sent = 0;
    int exp_q[$];
    logic [31:0] rd;

    jlsp_lane_packer u_jlsp_lane_packer (
        .i_clock(i_clock), .i_nrst(i_nrst),
        .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
        .i_reg_write(i_reg_write), .i_reg_read(i_reg_read),
        .o_reg_rdata(o_reg_rdata), .i_frame_valid(i_frame_valid),
        .i_samples(i_samples), .o_frame_ready(o_frame_ready),
        .o_octet(o_octet), .o_octet_valid(o_octet_valid),
        .o_frame_first(o_frame_first), .o_frame_last(o_frame_last),
        .o_lane_count(o_lane_count)
    );

    jlsp_rx_model u_jlsp_rx_model (
        .i_clock(i_clock), .i_nrst(i_nrst), .i_octet(o_octet),
        .i_octet_valid(o_octet_valid), .i_frame_first(o_frame_first),
        .i_frame_last(o_frame_last)
    );

    // A 25 ns period gives the 40 MHz clock.
    initial begin
        forever #12.5 i_clock = ~i_clock;
    end

    ////////////////////////////////////////////////////////////////////////
    // Prints the counts and the verdict, then ends the run.
    task automatic finish_test();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test

    // A wait that runs out of its bound counts as a mismatch.
    task automatic hang();
        failures++;
        $display("mismatch wait expected done seen timeout");
        finish_test();
    endtask : hang

    // Compares a register or count value.
    task automatic chk_reg(input string what, input logic [31:0] exp,
                           input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk_reg

    // Compares one octet of the stream.
    task automatic chk_oct(input int idx, input logic [7:0] exp,
                           input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("mismatch octet %0d expected %h seen %h", idx, exp, got);
        end
    endtask : chk_oct

    ////////////////////////////////////////////////////////////////////////
    // Register port tasks; each is entered just after a rising edge. The
    // extra edge after a write keeps two strobe assignments apart.
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        i_reg_addr <= a;
        i_reg_wdata <= d;
        i_reg_write <= 1'b1;
        @(posedge i_clock);
        i_reg_write <= 1'b0;
        @(posedge i_clock);
    endtask : reg_wr

    // Read data stand only in the cycle after the strobe.
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        i_reg_addr <= a;
        i_reg_read <= 1'b1;
        @(posedge i_clock);
        i_reg_read <= 1'b0;
        @(posedge i_clock);
        d = o_reg_rdata;
    endtask : reg_rd

    ////////////////////////////////////////////////////////////////////////
    // Bench model: one bit stream, MSB first, pad zeros after each sample,
    // zero filled to whole octets, first bit in the top of each octet.
    task automatic model_frame(input int res, input int ser, input int n,
                               input jlsp_samples_t s);
        int bits[$];
        int b;
        bits = {};
        for (int c = 0; c < n; c++) begin
            for (int k = res - 1; k >= 0; k--) bits.push_back(s[c][k]);
            for (int k = 0; k < ser - res; k++) bits.push_back(0);
        end
        while (bits.size() % 8 != 0) bits.push_back(0);
        for (int o = 0; o < bits.size(); o += 8) begin
            b = 0;
            for (int k = 0; k < 8; k++) b = b * 2 + bits[o + k];
            exp_q.push_back(b);
        end
    endtask : model_frame

    // Sets one packing setup, sends two frames back to back with random
    // samples (upper unused bits too) and compares the whole stream.
    task automatic run_cfg(input int r, input int s, input int c);
        int n;
        int t;
        jlsp_samples_t smp;
        n = (c == 0) ? 8 : (c == 1) ? 4 : 2;
        reg_wr(REG_CTRL, 32'(8'h80 | (c << 4) | (s << 2) | r));
        chk_reg("lane_count", 32'(16 / n), 32'(o_lane_count));
        exp_q = {};
        u_jlsp_rx_model.got = {};
        for (int f = 0; f < 2; f++) begin
            for (int k = 0; k < CH_MAX; k++) smp[k] = 16'($urandom);
            i_samples <= smp;
            i_frame_valid <= 1'b1;
            model_frame(10 + 2 * r, 10 + 2 * s, n, smp);
            @(posedge i_clock);
            for (t = 0; o_frame_ready !== 1'b1; t++) begin
                if (t == 100) hang();
                @(posedge i_clock);
            end
            sent++;
        end
        i_frame_valid <= 1'b0;
        // The second frame is still on the link, so the status shows busy,
        // the lanes in use and every frame taken so far.
        reg_rd(REG_STATUS, rd);
        chk_reg("status_busy", {16'h0, 8'(sent), 4'h1, 4'(16 / n)}, rd);
        for (t = 0; u_jlsp_rx_model.got.size() < exp_q.size(); t++) begin
            if (t == 100) hang();
            @(posedge i_clock);
        end
        for (int k = 0; k < exp_q.size(); k++) begin
            chk_oct(k, 8'(exp_q[k]), u_jlsp_rx_model.got[k]);
        end
        repeat (2) @(posedge i_clock);
        chk_reg("octets", exp_q.size(), u_jlsp_rx_model.got.size());
    endtask : run_cfg

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        void'($urandom(29));
        repeat (4) @(posedge i_clock);
        i_nrst <= 1'b1;
        @(posedge i_clock);
        reg_rd(REG_CTRL, rd);
        chk_reg("ctrl_reset", 32'(CTRL_RESET), rd);
        reg_rd(REG_STATUS, rd);
        chk_reg("status_reset", 32'h2, rd);
        reg_wr(4'h8, 32'hff);
        reg_rd(4'h8, rd);
        chk_reg("unmapped", 32'h0, rd);
        reg_rd(REG_CTRL, rd);
        chk_reg("ctrl_kept", 32'h0, rd);
        // Every legal width pair with every channel count.
        for (int r = 0; r < 4; r++) begin
            for (int s = r; s < 4; s++) begin
                for (int c = 0; c < 3; c++) run_cfg(r, s, c);
            end
        end
        // Word narrower than the samples is a setup fault.
        reg_wr(REG_CTRL, 32'h86);
        reg_rd(REG_STATUS, rd);
        chk_reg("cfg_err_width", 32'h1, 32'(rd[5]));
        // The reserved channel code flags a fault and acts as eight.
        reg_wr(REG_CTRL, 32'h30);
        reg_rd(REG_STATUS, rd);
        chk_reg("cfg_err_cpl", 32'h22, {24'h0, rd[7:0]});
        // Two octets per sample is not built, so it only flags a fault.
        reg_wr(REG_CTRL, 32'h40);
        reg_rd(REG_STATUS, rd);
        chk_reg("cfg_err_two_oct", 32'h22, {24'h0, rd[7:0]});
        reg_wr(REG_CTRL, 32'h0);
        reg_rd(REG_STATUS, rd);
        chk_reg("status_end", {16'h0, 8'(sent), 8'h02}, rd);
        chk_reg("frames", sent, u_jlsp_rx_model.frames);
        chk_reg("framing", 32'h0, u_jlsp_rx_model.bad);
        finish_test();
    end

endmodule : tb
